// *** rtl/swm_master.sv ***
// Single-wire bus master: APB register file, transaction sequencer,
// event flags with mask and one level interrupt.
// Assumes one 40 MHz clock; the bus line is an external open-drain pin.
`timescale 1ns/1ps

// Summary of operation
// - Only enabled event flags can drive the interrupt output.
// - Finishing a generated bus reset sets the reset-complete flag.
// - Operation-complete flag at end of read or write; combined sets after read.
// - No presence answer to a reset sets the no-presence flag.
// - Line held low by another party while the slot engine is idle sets the bus-stuck flag.
// - End of a DMA-driven sequence sets the DMA-complete flag.
// - Raw and masked views of the event flags are readable.
// - Bit count 1 to 32; exactly that many bits move.
// - Reset, write, read request bits combine; reset goes before data.
// - With write and read both requested, the write phase finishes first.
// - Written bits come from the 32-bit write data word.
// - Read data defaults to ones; unpulled bits read as one.
// - Busy status shows while reset, write or read runs.
// - Software clears any chosen flags; cleared flags stop the interrupt.
module swm_master
  import swm_pkg::*;
#(
  parameter int RST_LOW_C = RST_LOW_CYC,
  parameter int RST_REL_C = RST_REL_CYC,
  parameter int STUCK_C = STUCK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_n,
  input wire logic dma_seq_done,
  output logic irq
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RST, SEQ_WR, SEQ_RD} swm_seq_t;

  swm_slot_if sl ();

  swm_slot_engine #(
    .RST_LOW_C(RST_LOW_C),
    .RST_REL_C(RST_REL_C),
    .STUCK_C(STUCK_C)
  ) u_engine (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .sl(sl)
  );

  // Decode of a register byte address against the bus address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: a change counts once stages two and three agree
  logic [2:0] sync_reg, sync_next;
  logic line_f_reg, line_f_next;

  always_comb begin
    sync_next = {sync_reg[1:0], line_i};
    line_f_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_f_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= 3'h7;
      line_f_reg <= 1'b1;
    end else if (ce) begin
      sync_reg <= sync_next;
      line_f_reg <= line_f_next;
    end
  end

  assign sl.line_lvl = line_f_reg;
  assign line_o = 1'b0;              // Open drain: only ever pulls low
  assign line_oe_n = sl.line_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states while the clock enable is high
  logic acc, wr_acc, setup_rd, ctrl_wr, cnt_ok, mapped;
  logic [BITCNT_W-1:0] new_cnt;
  logic [OP_W-1:0] new_op;

  assign new_cnt = pwdata[BITCNT_LSB +: BITCNT_W];
  assign new_op = pwdata[OP_W-1:0];
  assign cnt_ok = (new_cnt != '0) && (new_cnt <= BITCNT_MAX);
  assign mapped = hit(paddr, REG_CTRL) || hit(paddr, REG_WDATA) || hit(paddr, REG_RDATA)
    || hit(paddr, REG_STATUS) || hit(paddr, REG_RIS) || hit(paddr, REG_IMR)
    || hit(paddr, REG_MIS);
  assign acc = psel && penable && ce;
  assign wr_acc = acc && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign ctrl_wr = wr_acc && hit(paddr, REG_CTRL);
  assign pready = ce;
  // Unmapped address, or a control write with an operation and an out-of-range bit count, is answered with an error
  assign pslverr = psel && penable && (!mapped || (pwrite && hit(paddr, REG_CTRL)
    && new_op != '0 && !cnt_ok));

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer and register file
  swm_seq_t state_reg, state_next;
  logic [OP_W-1:0] op_reg, op_next;
  logic [BITCNT_W-1:0] cnt_reg, cnt_next, idx_reg, idx_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, prdata_reg, prdata_next;
  logic [EVT_N-1:0] ris_reg, ris_next, imr_reg, imr_next, evt_set, evt_clr;
  logic nopres_reg, nopres_next, stuck_d_reg, start_reg, start_next, wbit_reg, wbit_next;
  swm_cmd_t cmd_reg, cmd_next;
  logic go, last_bit;

  // Writes to control while busy are dropped; software is expected to wait
  assign go = ctrl_wr && state_reg == SEQ_IDLE && new_op != '0 && cnt_ok;
  assign last_bit = (idx_reg == cnt_reg - 1'b1);
  assign sl.start = start_reg;
  assign sl.cmd = cmd_reg;
  assign sl.wbit = wbit_reg;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    nopres_next = nopres_reg;
    start_next = 1'b0;
    cmd_next = cmd_reg;
    wbit_next = wbit_reg;
    evt_set = '0;
    if (wr_acc && hit(paddr, REG_WDATA)) begin
      wdata_next = pwdata;
    end
    case (state_reg)
      SEQ_IDLE: begin
        if (go) begin
          op_next = new_op;
          cnt_next = new_cnt;
          idx_next = '0;
          start_next = 1'b1;
          if (new_op[OP_RESET_BIT]) begin
            state_next = SEQ_RST;
            cmd_next = CMD_RESET;
          end else if (new_op[OP_WRITE_BIT]) begin
            state_next = SEQ_WR;
            cmd_next = CMD_WRITE;
            wbit_next = wdata_reg[0];
          end else begin
            state_next = SEQ_RD;
            cmd_next = CMD_READ;
            rdata_next = RDATA_ONES;
          end
        end
      end
      SEQ_RST: begin
        if (sl.done) begin
          evt_set[EVT_RESET] = 1'b1;
          evt_set[EVT_NOPRES] = !sl.presence;
          nopres_next = !sl.presence;
          if (op_reg[OP_WRITE_BIT]) begin
            state_next = SEQ_WR;
            start_next = 1'b1;
            cmd_next = CMD_WRITE;
            wbit_next = wdata_reg[0];
          end else if (op_reg[OP_READ_BIT]) begin
            state_next = SEQ_RD;
            start_next = 1'b1;
            cmd_next = CMD_READ;
            rdata_next = RDATA_ONES;
          end else begin
            state_next = SEQ_IDLE;
          end
        end
      end
      SEQ_WR: begin
        if (sl.done) begin
          if (!last_bit) begin
            idx_next = idx_reg + 1'b1;
            start_next = 1'b1;
            wbit_next = wdata_reg[5'(idx_reg + 1'b1)];
          end else if (op_reg[OP_READ_BIT]) begin
            // Read phase only after the last written bit
            state_next = SEQ_RD;
            idx_next = '0;
            start_next = 1'b1;
            cmd_next = CMD_READ;
            rdata_next = RDATA_ONES;
          end else begin
            state_next = SEQ_IDLE;
            evt_set[EVT_OP] = 1'b1;
          end
        end
      end
      SEQ_RD: begin
        if (sl.done) begin
          rdata_next[5'(idx_reg)] = sl.rbit;
          if (!last_bit) begin
            idx_next = idx_reg + 1'b1;
            start_next = 1'b1;
          end else begin
            state_next = SEQ_IDLE;
            evt_set[EVT_OP] = 1'b1;
          end
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
    evt_set[EVT_STUCK] = sl.stuck && !stuck_d_reg;
    evt_set[EVT_DMA] = dma_seq_done;
  end

  // Flag and mask updates; a set in the clearing cycle wins
  always_comb begin
    evt_clr = (wr_acc && hit(paddr, REG_RIS)) ? pwdata[EVT_N-1:0] : '0;
    ris_next = (ris_reg & ~evt_clr) | evt_set;
    imr_next = (wr_acc && hit(paddr, REG_IMR)) ? pwdata[EVT_N-1:0] : imr_reg;
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = '0;
      if (hit(paddr, REG_CTRL)) begin
        prdata_next[OP_W-1:0] = op_reg;
        prdata_next[BITCNT_LSB +: BITCNT_W] = cnt_reg;
      end else if (hit(paddr, REG_WDATA)) begin
        prdata_next = wdata_reg;
      end else if (hit(paddr, REG_RDATA)) begin
        prdata_next = rdata_reg;
      end else if (hit(paddr, REG_STATUS)) begin
        prdata_next[ST_BUSY] = (state_reg != SEQ_IDLE);
        prdata_next[ST_NOPRES] = nopres_reg;
        prdata_next[ST_STUCK] = sl.stuck;
      end else if (hit(paddr, REG_RIS)) begin
        prdata_next[EVT_N-1:0] = ris_reg;
      end else if (hit(paddr, REG_IMR)) begin
        prdata_next[EVT_N-1:0] = imr_reg;
      end else if (hit(paddr, REG_MIS)) begin
        prdata_next[EVT_N-1:0] = ris_reg & imr_reg;
      end
    end
  end

  // Register stage for the sequencer and register file
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SEQ_IDLE;
      op_reg <= '0;
      cnt_reg <= '0;
      idx_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= RDATA_ONES;
      prdata_reg <= '0;
      ris_reg <= '0;
      imr_reg <= '0;
      nopres_reg <= 1'b0;
      stuck_d_reg <= 1'b0;
      start_reg <= 1'b0;
      cmd_reg <= CMD_RESET;
      wbit_reg <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      prdata_reg <= prdata_next;
      ris_reg <= ris_next;
      imr_reg <= imr_next;
      nopres_reg <= nopres_next;
      stuck_d_reg <= sl.stuck;
      start_reg <= start_next;
      cmd_reg <= cmd_next;
      wbit_reg <= wbit_next;
    end
  end

  assign prdata = prdata_reg;
  // Level interrupt, gated per source by the mask
  assign irq = |(ris_reg & imr_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Checks; a frozen clock enable suspends them
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  irq_mask_gate_a: assert property ((imr_reg == '0) |-> !irq)
    else $error("interrupt high with every source masked");
  reset_done_flag_a: assert property (
    (state_reg == SEQ_RST && sl.done) |=> ris_reg[EVT_RESET])
    else $error("reset complete flag not set");
  combined_op_a: assert property (
    (state_reg == SEQ_WR && sl.done && last_bit && op_reg[OP_READ_BIT])
      |=> !$rose(ris_reg[EVT_OP]) && state_reg == SEQ_RD)
    else $error("operation complete raised before read phase");
  read_op_done_a: assert property (
    (state_reg == SEQ_RD && sl.done && last_bit) |=> ris_reg[EVT_OP] && state_reg == SEQ_IDLE)
    else $error("operation complete missing after read");
  no_presence_a: assert property (
    (state_reg == SEQ_RST && sl.done && !sl.presence) |=> ris_reg[EVT_NOPRES])
    else $error("no presence flag not set");
  bus_stuck_a: assert property ($rose(sl.stuck) |=> ris_reg[EVT_STUCK])
    else $error("bus stuck flag not set");
  dma_done_a: assert property (dma_seq_done |=> ris_reg[EVT_DMA])
    else $error("dma complete flag not set");
  masked_view_a: assert property (
    (setup_rd && hit(paddr, REG_MIS)) |=> prdata == ($past(ris_reg & imr_reg) & 32'h1f))
    else $error("masked view wrong");
  bit_index_a: assert property (
    (state_reg == SEQ_WR || state_reg == SEQ_RD) |-> idx_reg < cnt_reg)
    else $error("bit index beyond count");
  reset_first_a: assert property ((go && new_op[OP_RESET_BIT]) |=> state_reg == SEQ_RST)
    else $error("reset did not come first");
  write_then_read_a: assert property (
    (state_reg == SEQ_RD && $past(state_reg) == SEQ_WR) |-> $past(last_bit && sl.done))
    else $error("read began before write ended");
  read_ones_a: assert property (
    (state_reg == SEQ_RD && $past(state_reg) != SEQ_RD) |-> rdata_reg == RDATA_ONES)
    else $error("read data not preset to ones");
  busy_view_a: assert property (
    (go ##[1:3] (setup_rd && hit(paddr, REG_STATUS))) |=> prdata[ST_BUSY])
    else $error("busy not shown");
  flag_clear_a: assert property (
    (wr_acc && hit(paddr, REG_RIS) && pwdata[EVT_DMA] && !dma_seq_done) |=> !ris_reg[EVT_DMA])
    else $error("flag not cleared");
  flag_sticky_a: assert property (
    (ris_reg[EVT_RESET] && !(wr_acc && hit(paddr, REG_RIS) && pwdata[EVT_RESET]))
      |=> ris_reg[EVT_RESET])
    else $error("flag dropped without clear");

endmodule

// *** rtl/swm_pkg.sv ***
// Shared constants for the single-wire bus master: register map, fields,
// slot timing and the command set between sequencer and slot engine.
// Assumes a 40 MHz system clock; all times are converted to cycles here.
package swm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and slot timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_LOW_NS = 480000;     // Bus reset low phase
  localparam int RST_REL_NS = 480000;     // Presence window after release
  localparam int PRES_SAMPLE_NS = 70000;  // Presence sample after release
  localparam int SLOT_NS = 70000;         // One data slot with recovery
  localparam int W0_LOW_NS = 60000;       // Low time of a written zero
  localparam int W1_LOW_NS = 6000;        // Low time of a one or read start
  localparam int RD_SAMPLE_NS = 15000;    // Read sample from slot start
  localparam int STUCK_NS = 960000;       // Idle low time that means stuck

  // Least times round up, sample points round down
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_REL_CYC = (RST_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STUCK_CYC = (STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRES_SAMPLE_CYC = PRES_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int W0_LOW_CYC = (W0_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int W1_LOW_CYC = (W1_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_SAMPLE_CYC = RD_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RIS = 8'h10;
  localparam logic [7:0] REG_IMR = 8'h14;
  localparam logic [7:0] REG_MIS = 8'h18;

  // Control fields
  localparam int OP_RESET_BIT = 0;
  localparam int OP_WRITE_BIT = 1;
  localparam int OP_READ_BIT = 2;
  localparam int OP_W = 3;
  localparam int BITCNT_LSB = 8;
  localparam int BITCNT_W = 6;
  localparam logic [5:0] BITCNT_MAX = 6'h20;

  // Event bits, same layout in raw, mask and masked views
  localparam int EVT_RESET = 0;
  localparam int EVT_OP = 1;
  localparam int EVT_NOPRES = 2;
  localparam int EVT_STUCK = 3;
  localparam int EVT_DMA = 4;
  localparam int EVT_N = 5;

  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_NOPRES = 1;
  localparam int ST_STUCK = 2;

  localparam logic [31:0] RDATA_ONES = 32'hffffffff;

  typedef enum logic [1:0] {CMD_RESET, CMD_WRITE, CMD_READ} swm_cmd_t;

endpackage

// *** rtl/swm_slot_engine.sv ***
// Slot engine: one bus reset, one written bit or one read bit per start.
// Assumes a filtered line level and a start only while idle.
`timescale 1ns/1ps
module swm_slot_engine
  import swm_pkg::*;
#(
  parameter int RST_LOW_C = RST_LOW_CYC,
  parameter int RST_REL_C = RST_REL_CYC,
  parameter int STUCK_C = STUCK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  swm_slot_if.eng sl
);

  if (RST_LOW_C < 1 || RST_REL_C <= PRES_SAMPLE_CYC || STUCK_C < 2
      || STUCK_C >= 2 ** CNT_W || RST_LOW_C >= 2 ** CNT_W || RST_REL_C >= 2 ** CNT_W) begin : g_bad
    $error("slot engine timing out of range");
  end

  typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_REL} swm_eng_t;

  swm_eng_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, low_reg, low_next, rel_reg, rel_next;
  logic [CNT_W-1:0] smp_reg, smp_next;
  swm_cmd_t cmd_reg, cmd_next;
  logic done_reg, done_next, rbit_reg, rbit_next, pres_reg, pres_next;
  logic oe_n_reg, oe_n_next, stuck_reg, stuck_next;

  assign sl.done = done_reg;
  assign sl.rbit = rbit_reg;
  assign sl.presence = pres_reg;
  assign sl.stuck = stuck_reg;
  assign sl.line_oe_n = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Slot timing; idle low time is counted to find a held line
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    low_next = low_reg;
    rel_next = rel_reg;
    smp_next = smp_reg;
    cmd_next = cmd_reg;
    done_next = 1'b0;
    rbit_next = rbit_reg;
    pres_next = pres_reg;
    oe_n_next = oe_n_reg;
    stuck_next = stuck_reg;
    case (state_reg)
      ENG_IDLE: begin
        if (sl.start) begin
          cmd_next = sl.cmd;
          state_next = ENG_LOW;
          oe_n_next = 1'b0;
          cnt_next = '0;
          stuck_next = 1'b0;
          if (sl.cmd == CMD_RESET) begin
            low_next = CNT_W'(RST_LOW_C);
            rel_next = CNT_W'(RST_REL_C);
            smp_next = CNT_W'(PRES_SAMPLE_CYC);
          end else if (sl.cmd == CMD_WRITE && !sl.wbit) begin
            low_next = CNT_W'(W0_LOW_CYC);
            rel_next = CNT_W'(SLOT_CYC - W0_LOW_CYC);
            smp_next = CNT_W'(RD_SAMPLE_CYC - W1_LOW_CYC);
          end else begin
            low_next = CNT_W'(W1_LOW_CYC);
            rel_next = CNT_W'(SLOT_CYC - W1_LOW_CYC);
            smp_next = CNT_W'(RD_SAMPLE_CYC - W1_LOW_CYC);
          end
        end else if (!sl.line_lvl) begin
          // Saturate so a long hold keeps one level, not a wrap
          if (cnt_reg != CNT_W'(STUCK_C - 1)) begin
            cnt_next = cnt_reg + 1'b1;
          end else begin
            stuck_next = 1'b1;
          end
        end else begin
          cnt_next = '0;
          stuck_next = 1'b0;
        end
      end
      ENG_LOW: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == low_reg - 1'b1) begin
          oe_n_next = 1'b1;
          state_next = ENG_REL;
          cnt_next = '0;
        end
      end
      ENG_REL: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == smp_reg) begin
          if (cmd_reg == CMD_RESET) begin
            pres_next = !sl.line_lvl;
          end else begin
            rbit_next = sl.line_lvl;
          end
        end
        if (cnt_reg == rel_reg - 1'b1) begin
          done_next = 1'b1;
          state_next = ENG_IDLE;
          cnt_next = '0;
        end
      end
      default: state_next = ENG_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ENG_IDLE;
      cnt_reg <= '0;
      low_reg <= '0;
      rel_reg <= '0;
      smp_reg <= '0;
      cmd_reg <= CMD_RESET;
      done_reg <= 1'b0;
      rbit_reg <= 1'b1;
      pres_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      stuck_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      low_reg <= low_next;
      rel_reg <= rel_next;
      smp_reg <= smp_next;
      cmd_reg <= cmd_next;
      done_reg <= done_next;
      rbit_reg <= rbit_next;
      pres_reg <= pres_next;
      oe_n_reg <= oe_n_next;
      stuck_reg <= stuck_next;
    end
  end

endmodule

// *** rtl/swm_slot_if.sv ***
// Carrier between the transaction sequencer and the slot engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface swm_slot_if;
  import swm_pkg::*;
  logic start;
  swm_cmd_t cmd;
  logic wbit;
  logic line_lvl;
  logic done;
  logic rbit;
  logic presence;
  logic stuck;
  logic line_oe_n;
  modport ctrl (output start, cmd, wbit, line_lvl, input done, rbit, presence, stuck, line_oe_n);
  modport eng (input start, cmd, wbit, line_lvl, output done, rbit, presence, stuck, line_oe_n);
endinterface

// *** tb/single_wire_master_txn_events_bench.sv ***
// Bench: APB tasks drive the master against the slave model.
// Assumes shortened reset and stuck counts.
`timescale 1ns/1ps
module single_wire_master_txn_events_bench;
  import swm_pkg::*;
  logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic line_i, line_oe_n, dma_seq_done, irq, present_en, stuck_en, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [63:0] rd_pat, wr_log;
  logic [5:0] slot;
  int n_fail, compares, cyc;
  swm_master #(.RST_LOW_C(40), .RST_REL_C(3000), .STUCK_C(100)) swm_master_i (
    .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_i(line_i), .line_o(), .line_oe_n(line_oe_n), .dma_seq_done(dma_seq_done),
    .irq(irq));
  swm_slave_model swm_slave_model_i (.clk(clk), .rstn(rstn), .line_oe_n(line_oe_n),
    .present_en(present_en), .stuck_en(stuck_en), .rd_pat(rd_pat), .line_lvl(line_i),
    .wr_log(wr_log), .slot(slot));
  ////////////////////////////////////////////////////////////
  // One transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Reads a register and compares it
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), rv, exp);
  endtask
  // Software polls busy before the next launch
  task automatic wait_idle();
    apb(1'b0, REG_STATUS, 32'h0);
    while (rv[ST_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
  endtask
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, dma_seq_done, stuck_en} = '0;
    {ce, present_en} = 2'b11;
    paddr = '0;
    pwdata = '0;
    rd_pat = '1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(REG_RDATA, RDATA_ONES);
    rchk(REG_RIS, 32'h0);
    apb(1'b1, REG_CTRL, 32'h2);
    chk("cnt0", {31'h0, err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h2102);
    chk("cnt33", {31'h0, err}, 32'h1);
    rchk(REG_STATUS, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    // Bus reset then three written bits
    apb(1'b1, REG_WDATA, 32'h5);
    apb(1'b1, REG_CTRL, 32'h0303);
    rchk(REG_STATUS, 32'h1);
    wait_idle();
    chk("wr3", {29'h0, wr_log[2:0]}, 32'h5);
    chk("slots", {26'h0, slot}, 32'h3);
    rchk(REG_RIS, 32'h3);
    rchk(REG_MIS, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
    apb(1'b1, REG_IMR, 32'h2);
    rchk(REG_MIS, 32'h2);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, REG_RIS, 32'h2);
    rchk(REG_RIS, 32'h1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, REG_RIS, 32'h1f);
    // Reset, write two bits, then read two
    rd_pat <= ~64'h4;
    apb(1'b1, REG_WDATA, 32'h2);
    apb(1'b1, REG_CTRL, 32'h0207);
    repeat (10000) @(posedge clk);
    rchk(REG_STATUS, 32'h1);
    rchk(REG_RIS, 32'h1);
    wait_idle();
    chk("wr2", {30'h0, wr_log[1:0]}, 32'h2);
    rchk(REG_RDATA, 32'hfffffffe);
    rchk(REG_RIS, 32'h3);
    apb(1'b1, REG_RIS, 32'h1f);
    // Nobody answers; read bits not pulled
    present_en <= 1'b0;
    rd_pat <= '1;
    apb(1'b1, REG_CTRL, 32'h0405);
    wait_idle();
    rchk(REG_RDATA, RDATA_ONES);
    rchk(REG_RIS, 32'h7);
    rchk(REG_STATUS, 32'h2);
    apb(1'b1, REG_RIS, 32'h1f);
    // Line held low while idle
    stuck_en <= 1'b1;
    repeat (150) @(posedge clk);
    rchk(REG_STATUS, 32'h6);
    rchk(REG_RIS, 32'h8);
    stuck_en <= 1'b0;
    apb(1'b1, REG_RIS, 32'h1f);
    // DMA end pulse with the mask off
    apb(1'b1, REG_IMR, 32'h0);
    dma_seq_done <= 1'b1;
    @(posedge clk);
    dma_seq_done <= 1'b0;
    rchk(REG_RIS, 32'h10);
    chk("irq_dma", {31'h0, irq}, 32'h0);
    apb(1'b1, REG_RIS, 32'h1f);
    // Lone write then lone read: no reset slot in front
    apb(1'b1, REG_WDATA, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0102);
    wait_idle();
    chk("wr_lone", {31'h0, wr_log[4]}, 32'h1);
    chk("slot_wr", {26'h0, slot}, 32'h5);
    rchk(REG_RIS, 32'h2);
    rd_pat <= ~64'h20;
    apb(1'b1, REG_CTRL, 32'h0104);
    wait_idle();
    rchk(REG_RDATA, 32'hfffffffe);
    chk("slot_rd", {26'h0, slot}, 32'h6);
    // Reset alone raises only reset complete
    present_en <= 1'b1;
    apb(1'b1, REG_RIS, 32'h1f);
    apb(1'b1, REG_CTRL, 32'h0101);
    wait_idle();
    rchk(REG_RIS, 32'h1);
    rchk(REG_STATUS, 32'h0);
    chk("slot_rst", {26'h0, slot}, 32'h0);
    wrap_up();
  end
endmodule

// *** tb/swm_slave_model.sv ***
// Slave on the single-wire line: presence, read zeros, stuck low.
// Assumes a pull-up on the line and the master's active-low enable.
`timescale 1ns/1ps
module swm_slave_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line_oe_n,
  input wire logic present_en,
  input wire logic stuck_en,
  input wire logic [63:0] rd_pat,
  output logic line_lvl,
  output logic [63:0] wr_log,
  output logic [5:0] slot
);
  logic [15:0] low_len;
  logic [15:0] rel_cnt;
  logic pres_pend;
  logic rd_pend;
  logic pull;
  ////////////////////////////////////////////////////////////
  // Wired-and; pull covers the master's sample points
  assign pull = (pres_pend && rel_cnt > 16'd2000 && rel_cnt < 16'd2900) ||
    (rd_pend && rel_cnt != 16'h0 && rel_cnt < 16'd500);
  assign line_lvl = line_oe_n & ~pull & ~stuck_en;
  // Each low pulse is judged by its length at release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_len <= '0;
      rel_cnt <= '0;
      pres_pend <= 1'b0;
      rd_pend <= 1'b0;
      slot <= '0;
      wr_log <= '0;
    end else if (!line_oe_n) begin
      low_len <= low_len + 16'h1;
      rel_cnt <= '0;
    end else if (low_len != 16'h0) begin
      low_len <= '0;
      rel_cnt <= 16'h1;
      if (low_len < 16'd100) begin
        pres_pend <= present_en;
        rd_pend <= 1'b0;
        slot <= '0;
      end else begin
        pres_pend <= 1'b0;
        wr_log[slot] <= (low_len < 16'd1000);
        rd_pend <= ~rd_pat[slot];
        slot <= slot + 6'h1;
      end
    end else if (rel_cnt != 16'hffff) begin
      rel_cnt <= rel_cnt + 16'h1;
    end
  end
endmodule
